// ==== verilog/sqc_pkg.sv ====
// constants, types and helpers of the square-wave and ram-clear control
package sqc_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    // register map, bank 0 and bank 1
    localparam logic [6:0] REG_A_ADDR = 7'h0a;
    localparam logic [6:0] REG_B_ADDR = 7'h0b;
    localparam logic [6:0] REG_C_ADDR = 7'h0c;
    localparam logic [6:0] REG_D_ADDR = 7'h0d;
    localparam int TIME_REGS = 10;
    localparam logic [6:0] RAM_FIRST = 7'h0e;
    localparam int RAM_BYTES = 114;
    localparam logic [6:0] EXT_WINDOW = 7'h40;
    localparam logic [6:0] EXT_FIRST = 7'h48;
    localparam int EXT_REGS = 4;
    localparam logic [6:0] EXT_CTRL_ADDR = 7'h4b;
    // field positions
    localparam int A_RATE_LSB = 0;
    localparam int A_BANK_BIT = 4;
    localparam int A_OSC_EN_BIT = 5;
    localparam int A_CHAIN_RST_BIT = 6;
    localparam int A_BUSY_BIT = 7;
    localparam int B_SQW_EN_BIT = 3;
    localparam int X_FORCE_32K_ENABLE_BIT = 6;
    localparam int X_ABE_BIT = 7;
    // reset and fixed read values
    localparam logic [7:0] REG_A_RST = 8'h00;
    localparam logic [7:0] REG_B_RST = 8'h00;
    localparam logic [7:0] EXT_CTRL_RST = 8'h00;
    localparam logic [7:0] REG_C_VALUE = 8'h00;
    localparam logic [7:0] REG_D_VALUE = 8'h80;
    localparam logic [7:0] RAM_CLEAR_VALUE = 8'hff;
    // divider chain
    localparam int DIV_STAGES = 15;
    localparam int FIRST_TAP = 1;
    localparam int LAST_TAP = 13;
    // timing
    localparam int SYS_CLK_PERIOD_NS = 25;
    localparam int REC_TIME_NS = 20000;
    localparam int REC_CYCLES =
        (REC_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int REC_CNT_W = 12;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic wr;
        logic rd;
    } sqc_bus_req_t;

    typedef struct packed {
        logic vccAboveTrip;
        logic auxPresent;
    } sqc_supply_t;

    typedef enum logic [1:0] {
        GATE_CLOSED,
        GATE_RECOVER,
        GATE_OPEN
    } sqc_gate_t;

    // divider tap for a rate code; code 0 selects no tap
    function automatic logic [3:0] rate_tap(input logic [3:0] rs);
        logic [3:0] tap;
        tap = 4'h0;
        case (rs)
            4'h0: tap = 4'h0;
            4'h1: tap = 4'h6;
            4'h2: tap = 4'h7;
            default: tap = rs - 4'h2;
        endcase
        return tap;
    endfunction
endpackage

// ==== verilog/sqc_core.sv ====
// square-wave output, user ram clear and supply-gated register access
//
// Operation
// - ram clear input low sets all 114 user ram bytes to ff
// - ram clear leaves clock, control registers and extended area untouched
// - ram clear works whatever supply powers the part
// - primary supply rising above trip sets oscillator enable and force-32k
// - output drives a square wave when square-wave enable or force-32k set
// - force-32k set gives 32k output whatever the rate select says
// - force-32k clear makes output follow the rate select in register a
// - output source is one of 13 taps of a 15-stage divider
// - below trip, 32k kept when force-32k, aux enable set and aux present
// - output disabled and supply below trip puts the pin in high impedance
// - square-wave enable in register b, force-32k in extended register 4bh
// - below trip all writes ignored and reads get no answer
// - oscillator runs or stops by an enable bit in register a
// - 14 bytes of clock and control registers plus 114 bytes user ram
// - after supply rise access waits recovery time if chain is running
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module sqc_core (
    input wire logic sys_clk,
    input wire logic rst,
    input wire sqc_pkg::sqc_bus_req_t busReq,
    output logic [sqc_pkg::DATA_W-1:0] rdData,
    input wire sqc_pkg::sqc_supply_t supply,
    input wire logic userRamClearN,
    input wire logic crystalIn,
    output logic squareWaveOut,
    output logic squareWaveOeN,
    output logic accessOpen
);
    import sqc_pkg::*;

    logic [7:0] regA_reg;
    logic [7:0] regB_reg;
    logic [7:0] timeRegs_reg [TIME_REGS];
    logic [7:0] extRegs_reg [EXT_REGS];
    logic [7:0] userRam_reg [RAM_BYTES];
    logic vccPrev_reg;
    logic crySync1_reg;
    logic crySync2_reg;
    logic cryPrev_reg;
    logic [DIV_STAGES-1:0] div_reg;
    logic [DIV_STAGES-1:0] divNext;
    sqc_gate_t gate_reg;
    sqc_gate_t gate_next;
    logic [REC_CNT_W-1:0] recCnt_reg;
    logic [7:0] rdMux;
    logic powerRise;
    logic busOk;
    logic wrOk;
    logic bankSel;
    logic ramHit;
    logic extHit;
    logic [6:0] ramIdx;
    logic [6:0] extIdx;
    logic oscOn;
    logic chainRst;
    logic oscTick;
    logic cryEdge;
    logic force32k;
    logic sqwEnable;
    logic auxKeep;
    logic outDrive;
    logic [3:0] tapIdx;
    logic tapValid;
    logic tapEdge;
    logic tapLevel;

    // decode of control bits and address windows
    assign oscOn = regA_reg[A_OSC_EN_BIT];
    assign chainRst = regA_reg[A_CHAIN_RST_BIT];
    assign bankSel = regA_reg[A_BANK_BIT];
    assign force32k = extRegs_reg[EXT_REGS-1][X_FORCE_32K_ENABLE_BIT];
    assign sqwEnable = regB_reg[B_SQW_EN_BIT];
    assign powerRise = supply.vccAboveTrip & ~vccPrev_reg;
    assign busOk = accessOpen & supply.vccAboveTrip;
    assign wrOk = busOk & busReq.wr;
    assign ramHit = (busReq.addr >= RAM_FIRST) &
        (~bankSel | (busReq.addr < EXT_WINDOW));
    assign extHit = bankSel & (busReq.addr >= EXT_FIRST) &
        (busReq.addr <= EXT_CTRL_ADDR);
    assign ramIdx = busReq.addr - RAM_FIRST;
    assign extIdx = busReq.addr - EXT_FIRST;

    // primary supply level one cycle back, for the rising edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vccPrev_reg <= 1'b0;
        end else begin
            vccPrev_reg <= supply.vccAboveTrip;
        end
    end

    // register a: rate, bank, oscillator enable, chain reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regA_reg <= REG_A_RST;
        end else if (powerRise) begin
            regA_reg[A_OSC_EN_BIT] <= 1'b1;
        end else if (wrOk && busReq.addr == REG_A_ADDR) begin
            regA_reg <= busReq.wrData;
            regA_reg[A_BUSY_BIT] <= 1'b0; // read-only bit
        end
    end

    // register b: holds the square-wave enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regB_reg <= REG_B_RST;
        end else if (wrOk && busReq.addr == REG_B_ADDR) begin
            regB_reg <= busReq.wrData;
        end
    end

    // time and alarm bytes; the ram clear never reaches them
    always_ff @(posedge sys_clk) begin
        if (wrOk && busReq.addr < REG_A_ADDR) begin
            timeRegs_reg[busReq.addr[3:0]] <= busReq.wrData;
        end
    end

    // bank 1 extended registers, last one carries force-32k and aux enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            extRegs_reg[EXT_REGS-1] <= EXT_CTRL_RST;
        end else if (powerRise) begin
            extRegs_reg[EXT_REGS-1][X_FORCE_32K_ENABLE_BIT] <= 1'b1;
        end else if (wrOk && extHit) begin
            extRegs_reg[extIdx[1:0]] <= busReq.wrData;
        end
    end

    // user ram: one byte per entry, clear has priority and ignores supply
    genvar gi;
    generate
        for (gi = 0; gi < RAM_BYTES; gi++) begin : g_ram
            always_ff @(posedge sys_clk) begin
                if (!userRamClearN) begin
                    userRam_reg[gi] <= RAM_CLEAR_VALUE;
                end else if (wrOk && ramHit && ramIdx == 7'(gi)) begin
                    userRam_reg[gi] <= busReq.wrData;
                end
            end
        end
    endgenerate

    // read multiplexer
    always_comb begin
        rdMux = 8'h00;
        if (ramHit) begin
            rdMux = userRam_reg[ramIdx];
        end else if (extHit) begin
            rdMux = extRegs_reg[extIdx[1:0]];
        end else if (busReq.addr < REG_A_ADDR) begin
            rdMux = timeRegs_reg[busReq.addr[3:0]];
        end else if (busReq.addr == REG_A_ADDR) begin
            rdMux = regA_reg;
        end else if (busReq.addr == REG_B_ADDR) begin
            rdMux = regB_reg;
        end else if (busReq.addr == REG_C_ADDR) begin
            rdMux = REG_C_VALUE;
        end else if (busReq.addr == REG_D_ADDR) begin
            rdMux = REG_D_VALUE;
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (busReq.rd && busOk) begin
            rdData <= rdMux;
        end else begin
            rdData <= 8'h00; // no answer while gated
        end
    end

    // access gate: closed below trip, recovery wait after the rise while the chain runs
    always_comb begin
        gate_next = gate_reg;
        case (gate_reg)
            GATE_CLOSED: begin
                if (powerRise && oscOn && !chainRst) begin
                    gate_next = GATE_RECOVER;
                end else if (powerRise) begin
                    gate_next = GATE_OPEN;
                end
            end
            GATE_RECOVER: begin
                if (!supply.vccAboveTrip) begin
                    gate_next = GATE_CLOSED;
                end else if (recCnt_reg == REC_CNT_W'(REC_CYCLES - 1)) begin
                    gate_next = GATE_OPEN;
                end
            end
            GATE_OPEN: begin
                if (!supply.vccAboveTrip) begin
                    gate_next = GATE_CLOSED;
                end
            end
            default: gate_next = GATE_CLOSED;
        endcase
    end

    // gate state, recovery count and the open flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gate_reg <= GATE_CLOSED;
            recCnt_reg <= '0;
            accessOpen <= 1'b0;
        end else begin
            gate_reg <= gate_next;
            accessOpen <= (gate_next == GATE_OPEN);
            if (gate_reg == GATE_RECOVER) begin
                recCnt_reg <= recCnt_reg + 1'b1;
            end else begin
                recCnt_reg <= '0;
            end
        end
    end

    // oscillator input synchroniser and edge memory
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            crySync1_reg <= 1'b0;
            crySync2_reg <= 1'b0;
            cryPrev_reg <= 1'b0;
        end else begin
            crySync1_reg <= crystalIn;
            crySync2_reg <= crySync1_reg;
            cryPrev_reg <= crySync2_reg;
        end
    end

    assign cryEdge = oscOn & (crySync2_reg ^ cryPrev_reg);
    assign oscTick = oscOn & crySync2_reg & ~cryPrev_reg;
    assign divNext = div_reg + 1'b1;

    // 15-stage divider chain, held at zero while in reset
    always_ff @(posedge sys_clk) begin
        if (rst || chainRst) begin
            div_reg <= '0;
        end else if (oscTick) begin
            div_reg <= divNext;
        end
    end

    // tap selection from the rate code
    assign tapIdx = rate_tap(regA_reg[A_RATE_LSB +: 4]);
    assign tapValid = (tapIdx >= 4'(FIRST_TAP)) && (tapIdx <= 4'(LAST_TAP));
    assign tapLevel = divNext[tapIdx];
    assign tapEdge = oscTick & ~chainRst & (divNext[tapIdx] ^ div_reg[tapIdx]);
    assign auxKeep = force32k & extRegs_reg[EXT_REGS-1][X_ABE_BIT] &
        supply.auxPresent;
    assign outDrive = supply.vccAboveTrip ? (force32k | sqwEnable) : auxKeep;

    // output level: moves on edges of the chosen source, held low while not driven
    always_ff @(posedge sys_clk) begin
        if (rst || !outDrive) begin
            squareWaveOut <= 1'b0;
        end else if (force32k) begin
            if (cryEdge) begin
                squareWaveOut <= crySync2_reg;
            end
        end else if (tapEdge) begin
            squareWaveOut <= tapValid & tapLevel;
        end
    end

    // pin enable, low while driving
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            squareWaveOeN <= 1'b1;
        end else begin
            squareWaveOeN <= ~(supply.vccAboveTrip | auxKeep);
        end
    end

    a_ram_clear_all: assert property (@(posedge sys_clk)
        disable iff (rst) !userRamClearN |=> userRam_reg[0] == 8'hff &&
        userRam_reg[RAM_BYTES-1] == 8'hff)
        else $error("ram clear missed a byte");
    a_clear_spares_ctrl: assert property (@(posedge sys_clk)
        disable iff (rst) !userRamClearN && !busReq.wr && !powerRise |=>
        $stable(regA_reg) && $stable(regB_reg) &&
        $stable(extRegs_reg[EXT_REGS-1]))
        else $error("ram clear touched control registers");
    a_clear_on_backup: assert property (@(posedge sys_clk)
        disable iff (rst) !userRamClearN && !supply.vccAboveTrip |=>
        userRam_reg[RAM_BYTES/2] == 8'hff)
        else $error("ram clear ignored on backup supply");
    a_rise_sets_bits: assert property (@(posedge sys_clk)
        disable iff (rst) powerRise |=> oscOn && force32k)
        else $error("supply rise did not set enables");
    a_pin_driven: assert property (@(posedge sys_clk)
        disable iff (rst) supply.vccAboveTrip && (sqwEnable || force32k)
        |=> !squareWaveOeN)
        else $error("enabled output not driven");
    a_force_follows_osc: assert property (@(posedge sys_clk)
        disable iff (rst) force32k && cryEdge && outDrive |=>
        squareWaveOut == $past(crySync2_reg))
        else $error("forced output not following oscillator");
    a_tap_follows_rate: assert property (@(posedge sys_clk)
        disable iff (rst) !force32k && outDrive && tapEdge && tapValid |=>
        squareWaveOut == $past(tapLevel))
        else $error("output not following selected tap");
    a_no_glitch: assert property (@(posedge sys_clk)
        disable iff (rst) outDrive && !force32k && !tapEdge ##1 outDrive
        |-> $stable(squareWaveOut))
        else $error("output moved off a tap edge");
    a_aux_keeps_pin: assert property (@(posedge sys_clk)
        disable iff (rst) !supply.vccAboveTrip && auxKeep |=>
        !squareWaveOeN)
        else $error("aux-powered output not driven");
    a_hiz_below_trip: assert property (@(posedge sys_clk)
        disable iff (rst) !supply.vccAboveTrip && !auxKeep |=> squareWaveOeN)
        else $error("pin not released below trip");
    // a ram clear in the strobe cycle may move the ram legally, so skip it
    a_gated_write: assert property (@(posedge sys_clk)
        disable iff (rst) busReq.wr && !supply.vccAboveTrip && userRamClearN
        |=> $stable(regB_reg) && $stable(userRam_reg[0]))
        else $error("write taken below trip");
    a_gated_read: assert property (@(posedge sys_clk)
        disable iff (rst) busReq.rd && !accessOpen |=> rdData == 8'h00)
        else $error("read answered while gated");
    a_recovery_wait: assert property (@(posedge sys_clk)
        disable iff (rst) gate_reg == GATE_CLOSED && gate_next ==
        GATE_RECOVER |=> !accessOpen [*8])
        else $error("access opened before recovery time");

    c_ram_clear: cover property (@(posedge sys_clk) disable iff (rst)
        !userRamClearN ##1 userRamClearN);
    c_recovery_done: cover property (@(posedge sys_clk) disable iff (rst)
        gate_reg == GATE_RECOVER ##1 gate_reg == GATE_OPEN);
    c_aux_32k: cover property (@(posedge sys_clk) disable iff (rst)
        !supply.vccAboveTrip && auxKeep && cryEdge);
    c_tap_toggle: cover property (@(posedge sys_clk) disable iff (rst)
        !force32k && sqwEnable && tapEdge && tapValid);
endmodule

// ==== verification/sqc_host_model.sv ====
// host-side model that masters the register port
`timescale 1ns/1ps
module sqc_host_model (
    input wire logic sys_clk,
    output sqc_pkg::sqc_bus_req_t busReq,
    input wire logic [sqc_pkg::DATA_W-1:0] rdData
);
    import sqc_pkg::*;
    // bus idle from time zero
    initial busReq = '0;
    // one write strobe, then lines released with inverted values
    task automatic writeReg(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq <= '{addr: ~a, wrData: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    // one read strobe, data taken in the cycle after it only
    task automatic readReg(input logic [6:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        busReq <= '{addr: a, wrData: 8'h5a, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        busReq <= '{addr: ~a, wrData: 8'ha5, wr: 1'b0, rd: 1'b0};
        @(posedge sys_clk);
        d = rdData;
    endtask
endmodule

// ==== verification/square_wave_and_ram_clear_control_test.sv ====
// self-checking bench of the square-wave and ram-clear control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nErrors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module square_wave_and_ram_clear_control_test;
    import sqc_pkg::*;
    localparam int XH = 8; // crystal half period in sys_clk cycles, sped up
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    sqc_bus_req_t busReq;
    logic [7:0] rdData;
    sqc_supply_t supply = '{vccAboveTrip: 1'b1, auxPresent: 1'b0};
    logic userRamClearN = 1'b1;
    logic crystalIn = 1'b0;
    logic squareWaveOut;
    logic squareWaveOeN;
    logic accessOpen;
    int nErrors = 0;
    int nTests = 0;
    int seed = 32'h8a67;
    int xtalCnt = 0;
    int n;
    int q;
    logic [7:0] rv;
    logic [7:0] ram [0:113];
    logic [7:0] tm [0:9];

    always #12.5 sys_clk = ~sys_clk;

    // external oscillator on the crystal input, crystal output left open
    always @(posedge sys_clk) begin
        if (xtalCnt == XH - 1) begin
            xtalCnt <= 0;
            crystalIn <= ~crystalIn;
        end else begin
            xtalCnt <= xtalCnt + 1;
        end
    end

    sqc_core sqc_core_i (
        .sys_clk(sys_clk), .rst(rst), .busReq(busReq), .rdData(rdData),
        .supply(supply), .userRamClearN(userRamClearN),
        .crystalIn(crystalIn), .squareWaveOut(squareWaveOut),
        .squareWaveOeN(squareWaveOeN), .accessOpen(accessOpen)
    );
    sqc_host_model sqc_host_model_i (
        .sys_clk(sys_clk), .busReq(busReq), .rdData(rdData)
    );

    // output period in sys_clk cycles for a rate code
    function automatic int expPeriod(input int code);
        int tap;
        tap = (code == 1) ? 6 : (code == 2) ? 7 : code - 2;
        return (2 * XH) << (tap + 1);
    endfunction

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        sqc_host_model_i.writeReg(a, d);
    endtask
    task automatic rd(input logic [6:0] a);
        sqc_host_model_i.readReg(a, rv);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // cycles until the next rising output edge, bounded
    task automatic nextRise(output int c);
        logic p;
        c = 0;
        p = squareWaveOut;
        @(posedge sys_clk);
        c++;
        while (!(p === 1'b0 && squareWaveOut === 1'b1) && c < 20000) begin
            p = squareWaveOut;
            @(posedge sys_clk);
            c++;
        end
    endtask
    // full period after skipping the first, possibly short, one
    task automatic period(output int c);
        nextRise(c);
        nextRise(c);
    endtask
    // count output level changes over k cycles
    task automatic toggles(input int k, output int t);
        logic p;
        t = 0;
        p = squareWaveOut;
        repeat (k) begin
            @(posedge sys_clk);
            if (squareWaveOut !== p) t++;
            p = squareWaveOut;
        end
    endtask
    // wait for host access to open, return cycles waited
    task automatic waitOpen(output int c);
        c = 0;
        while (accessOpen !== 1'b1 && c < 2000) begin
            @(posedge sys_clk);
            c++;
        end
    endtask
    task automatic clearPulse;
        @(posedge sys_clk);
        userRamClearN <= 1'b0;
        @(posedge sys_clk);
        userRamClearN <= 1'b1;
    endtask

    task automatic finalReport;
        $display("errors %0d comparisons %0d", nErrors, nTests);
        if (nErrors == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (90000) @(posedge sys_clk);
        nErrors++;
        finalReport();
    end

    initial begin
        cyc(20);
        rst <= 1'b0;
        waitOpen(n);
        // power-up defaults, fixed and read-only places
        rd(REG_A_ADDR); `CHK("regA", 8'h20, rv)
        rd(REG_B_ADDR); `CHK("regB", 8'h00, rv)
        wr(REG_C_ADDR, 8'hff);
        wr(REG_D_ADDR, 8'h00);
        rd(REG_C_ADDR); `CHK("regC", 8'h00, rv)
        rd(REG_D_ADDR); `CHK("regD", 8'h80, rv)
        wr(REG_A_ADDR, 8'hb0);
        rd(REG_A_ADDR); `CHK("regA ro", 8'h30, rv)
        rd(EXT_CTRL_ADDR); `CHK("ext4b", 8'h40, rv)
        rd(7'h40); `CHK("unmapped", 8'h00, rv)
        // forced 32k whatever the rate code
        wr(REG_A_ADDR, 8'h30 | (8'($random(seed)) & 8'h0f));
        period(q); `CHK("p32k", 2 * XH, q)
        `CHK("oeN 32k", 1'b0, squareWaveOeN)
        // oscillator stopped freezes the output
        wr(REG_A_ADDR, 8'h10);
        cyc(4);
        toggles(200, q); `CHK("osc off", 0, q)
        // force off, aux unused: aux enable kept clear
        wr(REG_A_ADDR, 8'h30);
        wr(EXT_CTRL_ADDR, 8'h00);
        cyc(8);
        toggles(300, q); `CHK("no square_wave_enable", 0, q)
        `CHK("out low", 1'b0, squareWaveOut)
        // rate codes through the divider taps
        wr(REG_A_ADDR, 8'h20);
        wr(REG_B_ADDR, 8'h08);
        for (int c = 1; c <= 9; c++) begin
            wr(REG_A_ADDR, 8'h20 | 8'(c));
            period(q); `CHK("rate period", expPeriod(c), q)
        end
        wr(REG_A_ADDR, 8'h20);
        // let the last high level fall at the next divider edge first
        cyc(40);
        toggles(200, q); `CHK("rate 0", 0, q)
        `CHK("rate 0 low", 1'b0, squareWaveOut)
        // ram clear touches only the 114 user bytes
        for (int i = 0; i < 10; i++) begin
            tm[i] = 8'($random(seed)) & 8'h7f;
            wr(7'(i), tm[i]);
        end
        for (int i = 0; i < RAM_BYTES; i++) begin
            ram[i] = 8'($random(seed));
            wr(RAM_FIRST + 7'(i), ram[i]);
        end
        supply.auxPresent <= 1'b1;
        wr(REG_A_ADDR, 8'h30);
        wr(EXT_CTRL_ADDR, 8'h80);
        wr(REG_A_ADDR, 8'h23);
        clearPulse();
        for (int i = 0; i < RAM_BYTES; i++) begin
            rd(RAM_FIRST + 7'(i)); `CHK("ram clr", 8'hff, rv)
        end
        for (int i = 0; i < 10; i++) begin
            rd(7'(i)); `CHK("time kept", tm[i], rv)
        end
        rd(REG_B_ADDR); `CHK("regB kept", 8'h08, rv)
        wr(REG_A_ADDR, 8'h33);
        rd(EXT_CTRL_ADDR); `CHK("ext kept", 8'h80, rv)
        wr(REG_A_ADDR, 8'h23);
        wr(RAM_FIRST, 8'h12);
        // supply below trip: no access, pin released, clear still works
        @(posedge sys_clk);
        supply.vccAboveTrip <= 1'b0;
        cyc(3);
        `CHK("closed", 1'b0, accessOpen)
        `CHK("oeN off", 1'b1, squareWaveOeN)
        wr(REG_B_ADDR, 8'h00);
        rd(REG_B_ADDR); `CHK("no read", 8'h00, rv)
        clearPulse();
        @(posedge sys_clk);
        supply.vccAboveTrip <= 1'b1;
        waitOpen(n);
        `CHK("recovery", 1'b1, n >= REC_CYCLES && n <= REC_CYCLES + 3)
        rd(REG_B_ADDR); `CHK("write ignored", 8'h08, rv)
        rd(RAM_FIRST); `CHK("clr on backup", 8'hff, rv)
        wr(REG_A_ADDR, 8'h33);
        rd(EXT_CTRL_ADDR); `CHK("rise sets", 8'hc0, rv)
        // below trip, 32k kept alive by the aux supply
        @(posedge sys_clk);
        supply.vccAboveTrip <= 1'b0;
        cyc(3);
        `CHK("oeN aux", 1'b0, squareWaveOeN)
        period(q); `CHK("p aux", 2 * XH, q)
        supply.auxPresent <= 1'b0;
        cyc(3);
        `CHK("oeN no aux", 1'b1, squareWaveOeN)
        finalReport();
    end
endmodule
